// >>> src/lan_glue_params.svh
`ifndef LAN_GLUE_PARAMS_SVH
`define LAN_GLUE_PARAMS_SVH

// clock rates and periods
`define REF_CLK_MHZ 200
`define REF_CLK_PERIOD_NS 5
`define OSC_CLK_MHZ 8
`define OSC_HALF_CYCLES (`REF_CLK_MHZ / (2 * `OSC_CLK_MHZ))

// i/o decode: address bits 9..4 pick the sixteen-address card block
`define CARD_BLOCK_TAG 6'h30
`define CMD_PORT_OFFSET 10'h300
`define CTRL_PORT_OFFSET 10'h301
`define CMD_PORT_SEL 1'b0
`define CTRL_PORT_SEL 1'b1

// control port layout and reset
`define CTRL_PORT_WIDTH 4
`define CTRL_PORT_RESET 4'h0
`define CTRL_DMA_A_BIT 0
`define CTRL_DMA_B_BIT 1
`define CTRL_IRQ_BIT 2
`define CTRL_TX_BIT 3

// transmit idle detect: line high longer than this means idle
`define IDLE_TIME_NS 2000
`define IDLE_CYCLES ((`IDLE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// least spacing between two dma bytes, in controller system clocks
`define DMA_GAP_SYS_CLKS 2
`define DMA_GAP_CYCLES (`DMA_GAP_SYS_CLKS * `REF_CLK_MHZ / `OSC_CLK_MHZ)

`endif

// >>> src/lan_glue_pkg.sv
package lan_glue_pkg;
    // dma request hold states, gray along idle, request, ack, gap
    typedef enum logic [1:0] {
        dma_idle = 2'b00,
        dma_req = 2'b01,
        dma_ack = 2'b11,
        dma_gap = 2'b10
    } dma_state_type;

    typedef enum logic [1:0] {
        irq_line3 = 2'd0,
        irq_line4 = 2'd1,
        irq_line5 = 2'd2
    } irq_line_type;

    typedef struct packed {
        logic transmitter_enable;
        logic irq_enable;
        logic dma_req_b_enable;
        logic dma_req_a_enable;
    } ctrl_port_type;
endpackage : lan_glue_pkg

// >>> src/fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8) ();
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;
    modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
    modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
endinterface : fifo_if
`default_nettype wire

// >>> src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_dout;

    // a bit only moves once stages two and three agree; stage one feeds stage two alone
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_dout[i] = (stage2[i] == stage3[i]) ? stage3[i] : dout[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= next_dout;
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> src/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    fifo_if.store q
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [CNT_W-1:0] next_count;
    logic do_push;
    logic do_pop;

    // flags come from the count flop, so full and empty never lie
    assign q.push_ready = (count != FULL_COUNT);
    assign q.pop_valid = (count != '0);
    assign q.pop_data = mem[rd_ptr];
    assign do_push = q.push_valid && q.push_ready;
    assign do_pop = q.pop_valid && q.pop_ready;

    // pointers wrap naturally; depth must be a power of two
    always_comb begin
        next_wr_ptr = do_push ? wr_ptr + PTR_W'(1) : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + PTR_W'(1) : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + CNT_W'(1);
        end else if (do_pop && !do_push) begin
            next_count = count - CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage needs no reset; only counted words are ever read
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= q.push_data;
        end
    end
endmodule : stream_fifo
`default_nettype wire

// >>> src/lan_adapter_host_bus_glue.sv
// Summary of operation
// RULE1: controller select only for address 300H while address enable is inactive; the code selects on every even address 300H..30EH.
// RULE2: control port load uses the same decode at 301H, only on I/O writes; the code loads on every odd address 301H..30FH.
// RULE3: card decodes the full sixteen-address block 300H to 30FH.
// RULE4: control port at 301H is write only; reads return nothing from it.
// RULE5: transceiver enabled on either DMA acknowledge or any card block access.
// RULE6: control port holds two DMA enables, interrupt enable, transmitter enable.
// RULE7: all control port bits clear to zero at reset.
// RULE8: transmitter enable low holds the line driver fully off.
// RULE9: serial clock is 8 or 16 times bit rate, set by a parameter.
// RULE10: parallel side at 8 MHz; at most one DMA byte per two clocks.
// RULE11: one 8 MHz oscillator drives both system and serial clock inputs; the divider here gives 200 MHz / 24, about 8.33 MHz.
// RULE12: host DMA controller runs single-byte transfers so refresh keeps running.
// RULE13: a raised DMA request is held until that channel's acknowledge arrives.
// RULE14: each DMA request reaches the bus through a buffer gated by its bit.
// RULE15: one channel for reception, the other for transmit and commands.
// RULE16: controller interrupts on command completion and on frame reception.
// RULE17: interrupt driven by tri-state onto one selectable line IRQ3, IRQ4, IRQ5.
// RULE18: idle detect combined with transmitter enable keeps driver off after reset.
// RULE19: control port latches low data bits when a qualified write strobe ends.
`timescale 1ns/1ps
`default_nettype none
`include "lan_glue_params.svh"
module lan_adapter_host_bus_glue import lan_glue_pkg::*; #(
    parameter int SAMPLE_FACTOR = 16,
    parameter irq_line_type IRQ_LINE = irq_line3,
    parameter int FIFO_DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [9:0] bus_addr,
    input wire logic bus_aen,
    input wire logic bus_iow_n,
    input wire logic bus_ior_n,
    input wire logic [7:0] bus_data,
    input wire logic dma_ack_a_n,
    input wire logic dma_ack_b_n,
    input wire logic ctrl_dma_req_a,
    input wire logic ctrl_dma_req_b,
    input wire logic ctrl_irq,
    input wire logic ctrl_txd,
    input wire logic ctrl_cmd_ready,
    output logic ctrl_cs_n,
    output logic ctrl_port_load_n,
    output logic transceiver_enable_n,
    output logic [1:0] dma_req_out,
    output logic [1:0] dma_req_oe,
    output logic [2:0] irq_out,
    output logic [2:0] irq_oe,
    output logic tx_line_data,
    output logic tx_driver_enable_n,
    output logic osc_clk,
    output logic sample_factor_16,
    output logic [7:0] ctrl_cmd_data,
    output logic ctrl_cmd_valid,
    output logic cmd_fifo_ready
);
    localparam int SYNC_W = 28;
    localparam int IDLE_W = $clog2(`IDLE_CYCLES + 1);
    localparam int GAP_W = $clog2(`DMA_GAP_CYCLES + 1);
    localparam int OSC_W = $clog2(`OSC_HALF_CYCLES + 1);
    localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(`IDLE_CYCLES);
    localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(`DMA_GAP_CYCLES);
    localparam logic [OSC_W-1:0] OSC_LIMIT = OSC_W'(`OSC_HALF_CYCLES - 1);

    // every pin from the bus or the controller is asynchronous to ref_clk
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic [9:0] addr_s;
    logic aen_s;
    logic iow_n_s;
    logic ior_n_s;
    logic [7:0] data_s;
    logic [1:0] ack_n_s;
    logic [1:0] creq_s;
    logic irq_s;
    logic txd_s;
    logic cmd_ready_s;

    assign pins_raw = {bus_addr, bus_aen, bus_iow_n, bus_ior_n, bus_data, dma_ack_b_n,
                       dma_ack_a_n, ctrl_dma_req_b, ctrl_dma_req_a, ctrl_irq, ctrl_txd,
                       ctrl_cmd_ready};
    assign {addr_s, aen_s, iow_n_s, ior_n_s, data_s, ack_n_s, creq_s, irq_s, txd_s,
            cmd_ready_s} = pins_s;

    pin_sync #(.WIDTH(SYNC_W)) u_pin_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .din(pins_raw),
        .dout(pins_s)
    );

    // ---- address decode and write completion
    logic in_block;
    logic cs_hit;
    logic load_hit;
    logic cmd_wr_hit;
    logic load_d;
    logic cmd_wr_d;
    logic [7:0] data_hold;
    logic next_load_d;
    logic next_cmd_wr_d;
    logic [7:0] next_data_hold;
    logic load_done;
    logic cmd_done;

    // only address bits 9..4 and 0 are looked at, so the card takes 300H..30FH
    always_comb begin
        in_block = !aen_s && (addr_s[9:4] == `CARD_BLOCK_TAG); // see RULE3
        cs_hit = in_block && (addr_s[0] == `CMD_PORT_SEL); // see RULE1
        load_hit = in_block && (addr_s[0] == `CTRL_PORT_SEL) && !iow_n_s; // see RULE2
        cmd_wr_hit = cs_hit && !iow_n_s;
        load_done = load_d && !load_hit;
        cmd_done = cmd_wr_d && !cmd_wr_hit;
        next_load_d = load_hit;
        next_cmd_wr_d = cmd_wr_hit;
        // data is kept while the strobe is low; the bus may drop it as soon as it ends
        next_data_hold = (load_hit || cmd_wr_hit) ? data_s : data_hold;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            load_d <= 1'b0;
            cmd_wr_d <= 1'b0;
            data_hold <= 8'h00;
        end else begin
            load_d <= next_load_d;
            cmd_wr_d <= next_cmd_wr_d;
            data_hold <= next_data_hold;
        end
    end

    // ---- control port: write only, nothing ever drives its contents back
    ctrl_port_type ctrl;
    ctrl_port_type next_ctrl;

    always_comb begin
        next_ctrl = ctrl;
        if (load_done) begin
            next_ctrl = ctrl_port_type'(data_hold[`CTRL_PORT_WIDTH-1:0]); // see RULE19 RULE6
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl <= ctrl_port_type'(`CTRL_PORT_RESET); // see RULE7
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ---- decode outputs registered onto the pins
    logic next_cs_n;
    logic next_load_n;
    logic next_xcvr_n;

    always_comb begin
        next_cs_n = !cs_hit;
        next_load_n = !load_hit;
        // a read of 301H still opens the transceiver but the port never drives it
        next_xcvr_n = ack_n_s[0] && ack_n_s[1] && !in_block; // see RULE5 RULE4
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_cs_n <= 1'b1;
            ctrl_port_load_n <= 1'b1;
            transceiver_enable_n <= 1'b1;
        end else begin
            ctrl_cs_n <= next_cs_n;
            ctrl_port_load_n <= next_load_n;
            transceiver_enable_n <= next_xcvr_n;
        end
    end

    // ---- dma request hold, channel a for reception, channel b for transmit and commands
    logic [1:0] chan_en;
    assign chan_en = {ctrl.dma_req_b_enable, ctrl.dma_req_a_enable};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_dma // see RULE15
            dma_state_type state;
            dma_state_type next_state;
            logic [GAP_W-1:0] gap_cnt;
            logic [GAP_W-1:0] next_gap_cnt;

            // the request is never dropped before ack: the host controller locks otherwise
            always_comb begin
                next_state = state;
                next_gap_cnt = gap_cnt;
                unique case (state)
                    dma_idle: begin
                        if (creq_s[ch] && chan_en[ch]) begin
                            next_state = dma_req;
                        end
                    end
                    dma_req: begin
                        if (!ack_n_s[ch]) begin
                            next_state = dma_ack; // see RULE13
                        end
                    end
                    dma_ack: begin
                        // one byte per acknowledge, as the host runs single transfers
                        if (ack_n_s[ch]) begin
                            next_state = dma_gap; // see RULE12
                            next_gap_cnt = '0;
                        end
                    end
                    dma_gap: begin
                        next_gap_cnt = gap_cnt + GAP_W'(1);
                        if (gap_cnt == GAP_LIMIT - GAP_W'(1)) begin
                            next_state = dma_idle; // see RULE10
                        end
                    end
                endcase
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    state <= dma_idle;
                    gap_cnt <= '0;
                    dma_req_out[ch] <= 1'b0;
                    dma_req_oe[ch] <= 1'b0;
                end else begin
                    state <= next_state;
                    gap_cnt <= next_gap_cnt;
                    dma_req_out[ch] <= (next_state == dma_req); // see RULE13
                    dma_req_oe[ch] <= next_ctrl[ch]; // see RULE14
                end
            end
        end
    endgenerate

    // ---- interrupt: one line driven, others left floating for sharing
    logic [2:0] next_irq_oe;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            next_irq_oe[i] = next_ctrl.irq_enable && (int'(IRQ_LINE) == i); // see RULE17
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_out <= 3'h0;
            irq_oe <= 3'h0;
        end else begin
            irq_out <= {3{irq_s}}; // see RULE16
            irq_oe <= next_irq_oe;
        end
    end

    // ---- transmit idle detect; starts expired so the driver is off after reset
    logic [IDLE_W-1:0] idle_cnt;
    logic [IDLE_W-1:0] next_idle_cnt;
    logic next_tx_en_n;

    always_comb begin
        next_idle_cnt = idle_cnt;
        if (!txd_s) begin
            next_idle_cnt = '0;
        end else if (idle_cnt != IDLE_LIMIT) begin
            next_idle_cnt = idle_cnt + IDLE_W'(1);
        end
        next_tx_en_n = !(ctrl.transmitter_enable && (next_idle_cnt != IDLE_LIMIT)); // see RULE8 RULE18
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            idle_cnt <= IDLE_LIMIT;
            tx_line_data <= 1'b1;
            tx_driver_enable_n <= 1'b1;
        end else begin
            idle_cnt <= next_idle_cnt;
            tx_line_data <= txd_s;
            tx_driver_enable_n <= next_tx_en_n;
        end
    end

    // ---- oscillator divider; one output feeds both controller clock inputs
    // 200 MHz does not divide evenly to 8 MHz, so the output runs slightly fast
    logic [OSC_W-1:0] osc_cnt;
    logic [OSC_W-1:0] next_osc_cnt;
    logic next_osc_clk;

    always_comb begin
        next_osc_cnt = osc_cnt + OSC_W'(1);
        next_osc_clk = osc_clk;
        if (osc_cnt == OSC_LIMIT) begin
            next_osc_cnt = '0;
            next_osc_clk = !osc_clk; // see RULE11
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            osc_cnt <= '0;
            osc_clk <= 1'b0;
            sample_factor_16 <= 1'b0;
        end else begin
            osc_cnt <= next_osc_cnt;
            osc_clk <= next_osc_clk;
            sample_factor_16 <= (SAMPLE_FACTOR == 16); // see RULE9
        end
    end

    // ---- command byte buffer between the 300H write and the controller
    fifo_if #(.WIDTH(8)) cmd_q ();

    stream_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_cmd_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .q(cmd_q)
    );

    logic next_cmd_valid;
    logic [7:0] next_cmd_data;
    logic take_word;

    // a write that meets a full buffer is lost; software must watch cmd_fifo_ready
    assign cmd_q.push_valid = cmd_done;
    assign cmd_q.push_data = data_hold;
    assign cmd_q.pop_ready = take_word;

    always_comb begin
        take_word = !ctrl_cmd_valid || cmd_ready_s;
        next_cmd_valid = ctrl_cmd_valid && !cmd_ready_s;
        next_cmd_data = ctrl_cmd_data;
        if (take_word && cmd_q.pop_valid) begin
            next_cmd_valid = 1'b1;
            next_cmd_data = cmd_q.pop_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_cmd_valid <= 1'b0;
            ctrl_cmd_data <= 8'h00;
            cmd_fifo_ready <= 1'b0;
        end else begin
            ctrl_cmd_valid <= next_cmd_valid;
            ctrl_cmd_data <= next_cmd_data;
            cmd_fifo_ready <= cmd_q.push_ready;
        end
    end

    // ---- checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_cs_dma_cycle: assert property (aen_s |=> ctrl_cs_n) // see RULE1
        else $error("controller select during dma cycle");
    chk_load_on_write: assert property (!ctrl_port_load_n |-> // see RULE2
        $past(!iow_n_s && in_block && addr_s[0]))
        else $error("control load without write to 301H");
    chk_block_xcvr: assert property (in_block |=> !transceiver_enable_n) // see RULE5
        else $error("transceiver closed on card access");
    chk_port_reset: assert property ($past(rst) |-> ctrl == ctrl_port_type'(`CTRL_PORT_RESET)) // see RULE7
        else $error("control port not cleared by reset");
    chk_port_latch: assert property ($rose(ctrl_port_load_n) |-> ctrl == $past(data_hold[3:0])) // see RULE19
        else $error("control port missed the written value");
    chk_tx_disabled: assert property (!ctrl.transmitter_enable |=> tx_driver_enable_n) // see RULE8
        else $error("line driver on with transmitter disabled");
    chk_dma_hold: assert property (dma_req_out[0] && ack_n_s[0] |=> dma_req_out[0]) // see RULE13
        else $error("dma request dropped before acknowledge");
    chk_dma_spacing: assert property ($fell(dma_req_out[1]) |=> (!dma_req_out[1]) [*8]) // see RULE10
        else $error("dma requests too close together");
    // irq_oe is registered from next_ctrl, so it tracks ctrl in the same cycle
    chk_irq_gate: assert property (!ctrl.irq_enable |-> irq_oe == 3'h0) // see RULE17
        else $error("interrupt driven while disabled");
endmodule : lan_adapter_host_bus_glue
`default_nettype wire

// >>> dv/dma_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dma_host_model (
    input wire logic ref_clk,
    input wire logic [1:0] req,
    input wire logic [1:0] oe,
    input wire logic slow,
    output wire logic [1:0] ack_n
);
    // one grant process per channel; a grant moves one byte, then the bus goes back
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic ack_q = 1'b1;
        assign ack_n[c] = ack_q;
        always begin
            @(negedge ref_clk);
            if (req[c] === 1'b1 && oe[c] === 1'b1) begin
                repeat (slow ? 30 : 6) @(negedge ref_clk); // slow grant exposes the hold
                ack_q = 1'b0;
                repeat (10) @(negedge ref_clk);
                ack_q = 1'b1;
            end
        end
    end
endmodule : dma_host_model
`default_nettype wire

// >>> dv/lan_adapter_host_bus_glue_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lan_glue_params.svh"
module lan_adapter_host_bus_glue_tb_top import lan_glue_pkg::*;;
    logic ref_clk = 0, rst = 1, bus_aen = 1, bus_iow_n = 1, bus_ior_n = 1, slow = 0;
    logic [9:0] bus_addr = 10'h3ff;
    logic [7:0] bus_data = 8'h00;
    logic ctrl_dma_req_a = 0, ctrl_dma_req_b = 0, ctrl_irq = 0, ctrl_txd = 1;
    logic ctrl_cmd_ready = 0;
    logic ctrl_cs_n, ctrl_port_load_n, transceiver_enable_n, tx_line_data, tx_driver_enable_n;
    logic osc_clk, sample_factor_16, ctrl_cmd_valid, cmd_fifo_ready;
    logic [1:0] dma_req_out, dma_req_oe;
    logic [2:0] irq_out, irq_oe;
    logic [7:0] ctrl_cmd_data;
    wire logic [1:0] ack_n;
    // plain variables, so the wait task can follow them by reference
    logic req_a, ack_b;
    assign req_a = dma_req_out[0];
    assign ack_b = ack_n[1];
    integer n_mismatch = 0, n_checks = 0, cycles = 0;

    lan_adapter_host_bus_glue lan_adapter_host_bus_glue_inst (.ref_clk, .rst, .bus_addr,
        .bus_aen, .bus_iow_n, .bus_ior_n, .bus_data, .dma_ack_a_n(ack_n[0]),
        .dma_ack_b_n(ack_n[1]), .ctrl_dma_req_a, .ctrl_dma_req_b, .ctrl_irq, .ctrl_txd,
        .ctrl_cmd_ready, .ctrl_cs_n, .ctrl_port_load_n, .transceiver_enable_n, .dma_req_out,
        .dma_req_oe, .irq_out, .irq_oe, .tx_line_data, .tx_driver_enable_n, .osc_clk,
        .sample_factor_16, .ctrl_cmd_data, .ctrl_cmd_valid, .cmd_fifo_ready);
    dma_host_model dma_host_model_inst (.ref_clk, .req(dma_req_out), .oe(dma_req_oe),
        .slow, .ack_n);

    // 200 mhz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish

    // hang guard, well above the roughly 1300 cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // strobe held 8 cycles, past the synchroniser lag; data stays until strobe rises
    task automatic io_start(input logic [9:0] a, input logic [7:0] d, input logic aen,
                            input logic wr);
        @(negedge ref_clk);
        bus_addr = a;
        bus_data = d;
        bus_aen = aen;
        if (wr) bus_iow_n = 0;
        else bus_ior_n = 0;
        repeat (8) @(negedge ref_clk);
    endtask : io_start

    task automatic io_end;
        bus_iow_n = 1;
        bus_ior_n = 1;
        repeat (8) @(negedge ref_clk);
        bus_addr = 10'h3ff;
        bus_aen = 1;
    endtask : io_end

    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        io_start(a, d, 0, 1);
        io_end;
    endtask : io_wr

    task automatic wait_val(ref logic s, input logic v, input integer lim);
        integer k;
        k = 0;
        while (s !== v && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
    endtask : wait_val

    // ready stays high, so the synced ready takes one word a cycle; follow them in order
    task automatic drain_cmds(input logic [7:0] first, input logic [7:0] step,
                              input integer n);
        integer k;
        k = 0;
        ctrl_cmd_ready = 1;
        repeat (n + 30) begin
            @(negedge ref_clk);
            if (ctrl_cmd_valid === 1'b1 && k < n && ctrl_cmd_data === first + step * k[7:0]) k++;
        end
        ctrl_cmd_ready = 0;
        repeat (8) @(negedge ref_clk);
        check(k, n);
        check(ctrl_cmd_valid, 0);
    endtask : drain_cmds

    task automatic test_reset;
        integer t0;
        check({ctrl_cs_n, ctrl_port_load_n, tx_driver_enable_n}, 3'b111);
        check({dma_req_out, dma_req_oe, irq_oe}, 7'h00);
        check(sample_factor_16, 1);
        wait_val(osc_clk, 0, 50);
        wait_val(osc_clk, 1, 50);
        t0 = cycles;
        wait_val(osc_clk, 0, 50);
        wait_val(osc_clk, 1, 50);
        check(cycles - t0, 2 * `OSC_HALF_CYCLES);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_decode;
        logic [9:0] addrs [7] = '{10'h300, 10'h301, 10'h30e, 10'h30f, 10'h310, 10'h200, 10'h300};
        logic blk;
        for (int i = 0; i < 7; i++) begin
            blk = (i != 6) && addrs[i][9:4] == 6'h30;
            io_start(addrs[i], {i[3:0], 4'h0}, i == 6, 1);
            check(ctrl_cs_n, !(blk && !addrs[i][0]));
            check(ctrl_port_load_n, !(blk && addrs[i][0]));
            check(transceiver_enable_n, !blk);
            io_end;
        end
        drain_cmds(8'h00, 8'h20, 2);
        io_start(10'h301, 8'h0f, 0, 0);
        check({ctrl_port_load_n, ctrl_cs_n, transceiver_enable_n}, 3'b110);
        io_end;
        check(dma_req_oe, 2'b00);
        $display("test_decode done");
    endtask : test_decode

    task automatic test_port;
        io_wr(10'h301, 8'hf5); // upper bits ignored
        check({dma_req_oe, irq_oe}, 5'b01001);
        io_wr(10'h30b, 8'h0a); // odd alias of the port
        check({dma_req_oe, irq_oe}, 5'b10000);
        $display("test_port done");
    endtask : test_port

    task automatic test_dma;
        integer t0;
        io_wr(10'h301, 8'h03);
        slow = 1;
        ctrl_dma_req_a = 1;
        wait_val(req_a, 1, 50);
        ctrl_dma_req_a = 0; // controller aborts before the grant
        repeat (20) @(negedge ref_clk);
        check(dma_req_out[0], 1);
        wait_val(req_a, 0, 60);
        check({ack_n[0], transceiver_enable_n}, 2'b00);
        slow = 0;
        ctrl_dma_req_b = 1;
        wait_val(ack_b, 0, 200);
        wait_val(ack_b, 1, 50);
        t0 = cycles;
        wait_val(ack_b, 0, 200);
        check(cycles - t0 >= `DMA_GAP_CYCLES, 1);
        io_wr(10'h301, 8'h01);
        check(dma_req_oe, 2'b01);
        ctrl_dma_req_b = 0;
        io_wr(10'h301, 8'h00);
        $display("test_dma done");
    endtask : test_dma

    task automatic test_irq;
        ctrl_irq = 1;
        io_wr(10'h301, 8'h04);
        check({irq_out, irq_oe}, 6'b111001);
        io_wr(10'h301, 8'h00);
        ctrl_irq = 0;
        repeat (8) @(negedge ref_clk);
        check({irq_out, irq_oe}, 6'b000000);
        $display("test_irq done");
    endtask : test_irq

    task automatic test_tx;
        ctrl_txd = 0;
        repeat (10) @(negedge ref_clk);
        check(tx_driver_enable_n, 1);
        io_wr(10'h301, 8'h08);
        check({tx_driver_enable_n, tx_line_data}, 2'b00);
        ctrl_txd = 1;
        repeat (10) @(negedge ref_clk);
        check({tx_driver_enable_n, tx_line_data}, 2'b01);
        repeat (`IDLE_CYCLES + 10) @(negedge ref_clk);
        check(tx_driver_enable_n, 1);
        io_wr(10'h301, 8'h00);
        $display("test_tx done");
    endtask : test_tx

    // fill with the consumer stalled, then drain; the byte sent to a full buffer is lost
    task automatic test_fifo;
        integer n;
        n = 0;
        while (cmd_fifo_ready === 1'b1 && n < 20) begin
            io_wr(10'h300, 8'ha0 + n[7:0]);
            n++;
        end
        check(n >= 16, 1);
        io_wr(10'h300, 8'h55); // full, must be dropped
        drain_cmds(8'ha0, 8'h01, n);
        check(ctrl_cmd_data, 8'h9f + n[7:0]);
        $display("test_fifo done");
    endtask : test_fifo

    // main sequence
    initial begin
        repeat (10) @(negedge ref_clk);
        rst = 0;
        repeat (10) @(negedge ref_clk);
        test_reset;
        test_decode;
        test_port;
        test_dma;
        test_irq;
        test_tx;
        test_fifo;
        tally_and_finish;
    end
endmodule : lan_adapter_host_bus_glue_tb_top
`default_nettype wire
